// ### logic/err_syn_map.svh
`ifndef ERR_SYN_MAP_SVH
`define ERR_SYN_MAP_SVH

// ----------------------------------------------------------------
// Issue syndrome field layout
// ----------------------------------------------------------------
`define ISS_WIDTH      25
`define ISS_IDS_BIT    24
`define ISS_AET_LSB    10
`define ISS_AET_MSB    12
`define ISS_FAULT_STATUS_CODE_FIELD_LSB   0
`define ISS_FAULT_STATUS_CODE_FIELD_MSB   5
`define ISS_RESET      25'h0000000

// ----------------------------------------------------------------
// Async error type encodings
// ----------------------------------------------------------------
`define AET_UNCONT     3'h0
`define AET_UNREC      3'h1
`define AET_RESTART    3'h2
`define AET_RECOV      3'h3
`define AET_CORRECTED  3'h6

// ----------------------------------------------------------------
// Flag values and fault status code
// ----------------------------------------------------------------
`define IDS_SET        1'h1
`define IDS_CLEAR      1'h0
`define FAULT_STATUS_CODE_FIELD_ASYNC     6'h11
`define FAULT_STATUS_CODE_FIELD_ZERO      6'h00

// ----------------------------------------------------------------
// Counter reset
// ----------------------------------------------------------------
`define COUNT_RESET    16'h0000

`endif

// ### logic/err_syn_pkg.sv
package err_syn_pkg;

  typedef enum logic [1:0] {
    RECOVER_NONE,
    RECOVER_REPAIR,
    RECOVER_NEVER
  } recover_class_type;

  typedef enum logic [2:0] {
    STATE_UNCONT,
    STATE_UNREC,
    STATE_RECOV,
    STATE_RESTART,
    STATE_CORRECTED,
    STATE_UNCAT,
    STATE_IMPL
  } err_state_type;

endpackage

// ### logic/error_recoverability_syndrome.sv
`timescale 1ns/1ps
`include "err_syn_map.svh"

module error_recoverability_syndrome
  import err_syn_pkg::*;
#(
  parameter int ADDR_W  = 64,
  parameter int COUNT_W = 16
) (
  input  wire logic                  clk_i,
  input  wire logic                  rstn_i,
  input  wire logic                  take_i,
  input  wire logic                  sys_err_i,
  input  wire logic                  to_64_i,
  input  wire logic                  silent_prop_i,
  input  wire logic                  latent_i,
  input  wire logic                  restart_corrects_i,
  input  wire logic                  restart_accesses_i,
  input  wire logic                  removable_i,
  input  wire logic [ADDR_W-1:0]     restart_addr_i,
  input  wire logic [ADDR_W-1:0]     pref_ret_addr_i,
  input  wire logic                  elect_never_i,
  input  wire logic                  elect_repair_i,
  input  wire logic                  impl_mech_i,
  input  wire logic                  contained_i,
  input  wire logic                  corrected_i,
  input  wire logic                  elect_uncat_i,
  input  wire logic                  elect_impl_i,
  input  wire logic [`ISS_WIDTH-2:0] impl_iss_i,
  input  wire logic                  syndrome_ack_i,
  output logic                       class_valid_o,
  output recover_class_type          class_o,
  output logic                       impl_repairable_o,
  output logic                       syndrome_written_o,
  output err_state_type              err_state_o,
  output logic [`ISS_WIDTH-1:0]      issue_syndrome_field_o,
  output logic                       syndrome_pending_o,
  output logic                       overrun_o,
  output logic [COUNT_W-1:0]         take_count_o
);

  initial begin
    if (ADDR_W < 1) begin
      $error("ADDR_W must be at least 1");
    end
    if (COUNT_W < 1 || COUNT_W > 16) begin
      $error("COUNT_W must be 1 to 16");
    end
  end

  // ----------------------------------------------------------------
  // Classification
  // ----------------------------------------------------------------
  recover_class_type cls_comb;
  logic              impl_rep_comb;

  recovery_classifier #(
    .ADDR_W (ADDR_W)
  ) u_classifier (
    .silent_prop_i      (silent_prop_i),
    .latent_i           (latent_i),
    .restart_corrects_i (restart_corrects_i),
    .restart_accesses_i (restart_accesses_i),
    .removable_i        (removable_i),
    .restart_addr_i     (restart_addr_i),
    .pref_ret_addr_i    (pref_ret_addr_i),
    .elect_never_i      (elect_never_i),
    .elect_repair_i     (elect_repair_i),
    .impl_mech_i        (impl_mech_i),
    .class_o            (cls_comb),
    .impl_repairable_o  (impl_rep_comb)
  );

  // ----------------------------------------------------------------
  // Stage one registers
  // ----------------------------------------------------------------
  logic                  take1_q;
  recover_class_type     cls_q;
  logic                  impl_rep_q;
  logic                  record_q;
  logic                  silent_q;
  logic                  contained_q;
  logic                  corrected_q;
  logic                  uncat_q;
  logic                  impl_q;
  logic [`ISS_WIDTH-2:0] impl_iss_q;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      take1_q <= 1'b0;
    end else begin
      take1_q <= take_i;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cls_q      <= RECOVER_NEVER;
      impl_rep_q <= 1'b0;
    end else if (take_i) begin
      cls_q      <= cls_comb;
      impl_rep_q <= impl_rep_comb;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      record_q    <= 1'b0;
      silent_q    <= 1'b0;
      contained_q <= 1'b0;
      corrected_q <= 1'b0;
      uncat_q     <= 1'b0;
      impl_q      <= 1'b0;
      impl_iss_q  <= '0;
    end else if (take_i) begin
      record_q    <= sys_err_i && to_64_i;
      silent_q    <= silent_prop_i;
      contained_q <= contained_i;
      corrected_q <= corrected_i;
      uncat_q     <= elect_uncat_i;
      impl_q      <= elect_impl_i;
      impl_iss_q  <= impl_iss_i;
    end
  end

  // ----------------------------------------------------------------
  // Error state selection
  // ----------------------------------------------------------------
  err_state_type state_d;

  // Uncategorized, impl and corrected flags take priority over the recoverability class
  always_comb begin
    if (uncat_q) begin
      state_d = STATE_UNCAT;
    end else if (impl_q) begin
      state_d = STATE_IMPL;
    end else if (corrected_q) begin
      state_d = STATE_CORRECTED;
    end else begin
      unique case (cls_q)
        RECOVER_NONE: begin
          state_d = STATE_RESTART;
        end
        RECOVER_REPAIR: begin
          state_d = STATE_RECOV;
        end
        RECOVER_NEVER: begin
          if (!silent_q && contained_q) begin
            state_d = STATE_UNREC;
          end else begin
            state_d = STATE_UNCONT;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Syndrome encoding
  // ----------------------------------------------------------------
  logic [2:0]            aet_d;
  logic [`ISS_WIDTH-1:0] iss_d;

  always_comb begin
    unique case (state_d)
      STATE_UNCONT: begin
        aet_d = `AET_UNCONT;
      end
      STATE_UNREC: begin
        aet_d = `AET_UNREC;
      end
      STATE_RESTART: begin
        aet_d = `AET_RESTART;
      end
      STATE_RECOV: begin
        aet_d = `AET_RECOV;
      end
      STATE_CORRECTED: begin
        aet_d = `AET_CORRECTED;
      end
      default: begin
        aet_d = `AET_UNCONT;
      end
    endcase
  end

  always_comb begin
    iss_d = `ISS_RESET;
    unique case (state_d)
      STATE_UNCAT: begin
        iss_d = `ISS_RESET;
      end
      STATE_IMPL: begin
        iss_d[`ISS_IDS_BIT]     = `IDS_SET;
        iss_d[`ISS_IDS_BIT-1:0] = impl_iss_q;
      end
      default: begin
        iss_d[`ISS_IDS_BIT]                 = `IDS_CLEAR;
        iss_d[`ISS_AET_MSB:`ISS_AET_LSB]   = aet_d;
        iss_d[`ISS_FAULT_STATUS_CODE_FIELD_MSB:`ISS_FAULT_STATUS_CODE_FIELD_LSB] = `FAULT_STATUS_CODE_FIELD_ASYNC;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Classification outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      class_valid_o     <= 1'b0;
      class_o           <= RECOVER_NEVER;
      impl_repairable_o <= 1'b0;
    end else begin
      class_valid_o <= take1_q;
      if (take1_q) begin
        class_o           <= cls_q;
        impl_repairable_o <= impl_rep_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Syndrome register
  // ----------------------------------------------------------------
  logic write_now;

  assign write_now = take1_q && record_q;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      syndrome_written_o <= 1'b0;
    end else begin
      syndrome_written_o <= write_now;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      err_state_o            <= STATE_UNCAT;
      issue_syndrome_field_o <= `ISS_RESET;
    end else if (write_now) begin
      err_state_o            <= state_d;
      issue_syndrome_field_o <= iss_d;
    end
  end

  // ----------------------------------------------------------------
  // Pending and overrun
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      syndrome_pending_o <= 1'b0;
    end else if (write_now) begin
      syndrome_pending_o <= 1'b1;
    end else if (syndrome_ack_i) begin
      syndrome_pending_o <= 1'b0;
    end
  end

  // New write over an unacknowledged one; clear wins over set
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      overrun_o <= 1'b0;
    end else if (write_now && syndrome_pending_o && !syndrome_ack_i) begin
      overrun_o <= 1'b1;
    end else if (syndrome_ack_i) begin
      overrun_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Exception counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      take_count_o <= COUNT_W'(`COUNT_RESET);
    end else if (take1_q && take_count_o != {COUNT_W{1'b1}}) begin
      take_count_o <= take_count_o + {{(COUNT_W-1){1'b0}}, 1'b1};
    end
  end

endmodule

// ### logic/recovery_classifier.sv
`timescale 1ns/1ps

module recovery_classifier
  import err_syn_pkg::*;
#(
  parameter int ADDR_W = 64
) (
  input  wire logic              silent_prop_i,
  input  wire logic              latent_i,
  input  wire logic              restart_corrects_i,
  input  wire logic              restart_accesses_i,
  input  wire logic              removable_i,
  input  wire logic [ADDR_W-1:0] restart_addr_i,
  input  wire logic [ADDR_W-1:0] pref_ret_addr_i,
  input  wire logic              elect_never_i,
  input  wire logic              elect_repair_i,
  input  wire logic              impl_mech_i,
  output recover_class_type      class_o,
  output logic                   impl_repairable_o
);

  logic addr_eq;
  logic none_ok;
  logic repair_ok;

  assign addr_eq = restart_addr_i == pref_ret_addr_i;

  assign none_ok = !silent_prop_i && (!latent_i || restart_corrects_i) && addr_eq
                   && !elect_never_i && !elect_repair_i;

  assign repair_ok = !silent_prop_i && addr_eq && !elect_never_i
                     && ((latent_i && restart_accesses_i && removable_i)
                         || elect_repair_i);

  // Repairs needing private mechanisms report as never
  assign impl_repairable_o = repair_ok && !none_ok && impl_mech_i;

  always_comb begin
    if (none_ok) begin
      class_o = RECOVER_NONE;
    end else if (repair_ok && !impl_mech_i) begin
      class_o = RECOVER_REPAIR;
    end else begin
      class_o = RECOVER_NEVER;
    end
  end

endmodule

// ### verification/err_source.sv
`timescale 1ns/1ps

module err_source (
  input  wire logic        clk_i,
  input  wire logic        go_i,
  input  wire logic [14:0] v_i,
  output logic             take_o,
  output logic [14:0]      q_o
);
  logic [14:0] last_q = 15'h0;

  // ----------------------------------------
  // Qualifiers only valid with the take pulse
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    last_q <= q_o;
  end
  assign take_o = go_i;
  assign q_o    = go_i ? v_i : ~last_q;
endmodule

// ### verification/error_recoverability_syndrome_assertions.sv
`timescale 1ns/1ps
`include "err_syn_map.svh"

module error_recoverability_syndrome_assertions
  import err_syn_pkg::*;
(
  input wire logic                  clk_i,
  input wire logic                  rstn_i,
  input wire logic                  take_i,
  input wire logic                  sys_err_i,
  input wire logic                  to_64_i,
  input wire logic                  silent_prop_i,
  input wire logic                  elect_never_i,
  input wire logic                  elect_uncat_i,
  input wire logic                  class_valid_o,
  input wire recover_class_type     class_o,
  input wire logic                  syndrome_written_o,
  input wire err_state_type         err_state_o,
  input wire logic [`ISS_WIDTH-1:0] issue_syndrome_field_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  // ----------------------------------------
  // Classification
  // ----------------------------------------
  property p_answer;
    take_i |-> ##2 class_valid_o;
  endproperty
  a_answer: assert property (p_answer) else $error("no class two cycles after take");
  property p_never;
    take_i && (silent_prop_i || elect_never_i) |-> ##2 class_o == RECOVER_NEVER;
  endproperty
  a_never: assert property (p_never) else $error("propagated error not unrecoverable");
  // ----------------------------------------
  // Syndrome recording
  // ----------------------------------------
  property p_uncat;
    take_i && sys_err_i && to_64_i && elect_uncat_i |->
      ##2 syndrome_written_o && err_state_o == STATE_UNCAT;
  endproperty
  a_uncat: assert property (p_uncat) else $error("uncategorized not recorded");
  property p_nowrite;
    take_i && !(sys_err_i && to_64_i) |-> ##2 !syndrome_written_o;
  endproperty
  a_nowrite: assert property (p_nowrite) else $error("syndrome written for other exception");
  property p_zero;
    syndrome_written_o && err_state_o == STATE_UNCAT |-> issue_syndrome_field_o == 25'h0;
  endproperty
  a_zero: assert property (p_zero) else $error("uncategorized syndrome not zero");
  property p_flag;
    syndrome_written_o && err_state_o == STATE_IMPL |-> issue_syndrome_field_o[24];
  endproperty
  a_flag: assert property (p_flag) else $error("impl syndrome flag clear");
  property p_other;
    syndrome_written_o && !(err_state_o inside {STATE_UNCAT, STATE_IMPL}) |->
      !issue_syndrome_field_o[24] && issue_syndrome_field_o[5:0] != 6'h0;
  endproperty
  a_other: assert property (p_other) else $error("type field not marked valid");
  property p_aet;
    syndrome_written_o && err_state_o inside {STATE_RESTART, STATE_RECOV} |->
      issue_syndrome_field_o[12:10] == {2'b01, err_state_o == STATE_RECOV};
  endproperty
  a_aet: assert property (p_aet) else $error("wrong error type encoding");
  property p_hold;
    !syndrome_written_o |-> $stable(issue_syndrome_field_o);
  endproperty
  a_hold: assert property (p_hold) else $error("syndrome changed without write");
endmodule

bind error_recoverability_syndrome error_recoverability_syndrome_assertions chk_u (
  .clk_i(clk_i), .rstn_i(rstn_i), .take_i(take_i), .sys_err_i(sys_err_i),
  .to_64_i(to_64_i), .silent_prop_i(silent_prop_i), .elect_never_i(elect_never_i),
  .elect_uncat_i(elect_uncat_i), .class_valid_o(class_valid_o), .class_o(class_o),
  .syndrome_written_o(syndrome_written_o), .err_state_o(err_state_o),
  .issue_syndrome_field_o(issue_syndrome_field_o)
);

// ### verification/error_recoverability_syndrome_tb.sv
`timescale 1ns/1ps

module error_recoverability_syndrome_tb;
  import err_syn_pkg::*;
  typedef struct {
    logic [14:0]       v;
    recover_class_type c;
    err_state_type     s;
    logic              r;
  } row_type;
  logic              clk_i = 1'b0;
  logic              rstn_i = 1'b0;
  logic              go = 1'b0;
  logic              ack = 1'b0;
  logic [14:0]       v = 15'h0;
  logic [63:0]       pa = 64'h0000_0000_4000_1000;
  logic              take, cv, irep, wr, pend, ovr;
  logic [14:0]       q;
  logic [24:0]       issue_syndrome_field, last_iss;
  logic [15:0]       cnt;
  recover_class_type cls;
  err_state_type     st;
  int                n_mismatch = 0;
  int                cmp_count = 0;
  int                n_take = 0;
  row_type           rows[12] = '{
    '{15'h6000, RECOVER_NONE, STATE_RESTART, 1'h0}, '{15'h6001, RECOVER_NEVER, STATE_UNCONT, 1'h0},
    '{15'h601a, RECOVER_REPAIR, STATE_RECOV, 1'h0}, '{15'h6220, RECOVER_NEVER, STATE_UNREC, 1'h0},
    '{15'h6080, RECOVER_REPAIR, STATE_RECOV, 1'h0}, '{15'h6240, RECOVER_NEVER, STATE_UNREC, 1'h0},
    '{15'h611a, RECOVER_NEVER, STATE_UNCONT, 1'h1}, '{15'h6400, RECOVER_NONE, STATE_CORRECTED, 1'h0},
    '{15'h7801, RECOVER_NEVER, STATE_UNCAT, 1'h0}, '{15'h7400, RECOVER_NONE, STATE_IMPL, 1'h0},
    '{15'h6006, RECOVER_NONE, STATE_RESTART, 1'h0}, '{15'h2001, RECOVER_NEVER, STATE_UNCAT, 1'h0}};

  err_source src (.clk_i(clk_i), .go_i(go), .v_i(v), .take_o(take), .q_o(q));

  error_recoverability_syndrome DUT (
    .clk_i(clk_i), .rstn_i(rstn_i), .take_i(take), .sys_err_i(q[13]), .to_64_i(q[14]),
    .silent_prop_i(q[0]), .latent_i(q[1]), .restart_corrects_i(q[2]),
    .restart_accesses_i(q[3]), .removable_i(q[4]), .pref_ret_addr_i(pa),
    .restart_addr_i(q[5] ? ~pa : pa), .elect_never_i(q[6]), .elect_repair_i(q[7]),
    .impl_mech_i(q[8]), .contained_i(q[9]), .corrected_i(q[10]), .elect_uncat_i(q[11]),
    .elect_impl_i(q[12]), .impl_iss_i({9'h0, q} ^ 24'ha5a5a5), .syndrome_ack_i(ack),
    .class_valid_o(cv), .class_o(cls), .impl_repairable_o(irep), .syndrome_written_o(wr),
    .err_state_o(st), .issue_syndrome_field_o(issue_syndrome_field), .syndrome_pending_o(pend),
    .overrun_o(ovr), .take_count_o(cnt)
  );

  // ----------------------------------------
  // Clock, watchdog, helpers
  // ----------------------------------------
  initial forever #12.5 clk_i = ~clk_i;
  initial begin
    #75000;
    n_mismatch++;
    wrap_up();
  end
  task automatic chk(input string n, input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0h seen %0h", n, exp, seen);
    end
  endtask
  function automatic logic [24:0] exp_iss(input err_state_type s, input logic [14:0] x);
    logic [2:0] t;
    t = s == STATE_UNREC ? 3'h1 : s == STATE_RESTART ? 3'h2 : s == STATE_RECOV ? 3'h3 :
        s == STATE_CORRECTED ? 3'h6 : 3'h0;
    if (s == STATE_UNCAT) return 25'h0;
    if (s == STATE_IMPL) return {1'b1, {9'h0, x} ^ 24'ha5a5a5};
    return {12'h0, t, 4'h0, 6'h11};
  endfunction
  task automatic chk_reset;
    chk("class_rst", cls, RECOVER_NEVER);
    chk("state_rst", st, STATE_UNCAT);
    chk("iss_rst", issue_syndrome_field, 25'h0);
    chk("flags_rst", {cv, wr, pend, ovr, irep}, 5'h0);
    chk("count_rst", cnt, 16'h0);
  endtask
  task automatic run(input row_type r);
    go = 1'b1;
    v = r.v;
    pa = pa + 64'h10;
    n_take++;
    @(posedge clk_i);
    #1 go = 1'b0;
    @(posedge clk_i);
    #1;
    chk("valid", cv, 1'h1);
    chk("class", cls, r.c);
    chk("repairable", irep, r.r);
    if (r.v[13] & r.v[14]) begin
      last_iss = exp_iss(r.s, r.v);
      chk("written", wr, 1'h1);
      chk("state", st, r.s);
      chk("syndrome", issue_syndrome_field, last_iss);
    end else begin
      chk("written", wr, 1'h0);
      chk("hold", issue_syndrome_field, last_iss);
    end
    chk("count", cnt, n_take[15:0]);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clk_i);
    chk_reset();
    #1 rstn_i = 1'b1;
    foreach (rows[i]) run(rows[i]);
    $display("table rows done");
    ack = 1'b1;
    @(posedge clk_i);
    #1 ack = 1'b0;
    go = 1'b1;
    v = 15'h6000;
    @(posedge clk_i);
    #1 v = 15'h601a;
    @(posedge clk_i);
    #1 go = 1'b0;
    chk("b2b_first", {cls, st, pend, ovr}, {RECOVER_NONE, STATE_RESTART, 2'b10});
    @(posedge clk_i);
    #1;
    chk("b2b_second", {cv, cls, st, ovr}, {1'b1, RECOVER_REPAIR, STATE_RECOV, 1'b1});
    ack = 1'b1;
    @(posedge clk_i);
    #1 ack = 1'b0;
    chk("ack_clear", {pend, ovr}, 2'h0);
    $display("back to back done");
    rstn_i = 1'b0;
    #1;
    chk_reset();
    repeat (2) @(posedge clk_i);
    #1 rstn_i = 1'b1;
    n_take = 0;
    run(rows[0]);
    $display("mid run reset done");
    wrap_up();
  end
endmodule
